// File: src/asrh_pkg.sv
// package for the host-side async sram access controller
package asrh_pkg;
  // device organisation
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned WORDS = 8192;
  // clock rate in kHz (10 MHz)
  localparam int unsigned CLK_KHZ = 10000;
  // pin timings in ns (parameters, generous defaults)
  localparam int unsigned MIN_WRITE_PULSE_TIME_NS = 15;
  localparam int unsigned WRITE_TO_OUTPUT_FLOAT_DELAY_NS = 10;
  localparam int unsigned DATA_SETUP_TO_WRITE_END_NS = 11;
  localparam int unsigned READ_ACCESS_NS = 20;
  // least times round up to whole cycles, never below one
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_KHZ + 999999) / 1000000;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned WP_CYC = ns_to_cyc(MIN_WRITE_PULSE_TIME_NS);
  localparam int unsigned WP_OE_CYC = ns_to_cyc(
    WRITE_TO_OUTPUT_FLOAT_DELAY_NS + DATA_SETUP_TO_WRITE_END_NS);
  localparam int unsigned RD_CYC = ns_to_cyc(READ_ACCESS_NS);
  localparam int unsigned CNT_W = 4;
  // pins toward the device
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic select_active_low;
    logic select_active_high;
    logic write_n;
    logic output_enable_n;
  } asrh_pins_s;
  // user request
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrh_req_s;
endpackage

// File: src/asrh_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module asrh_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // stage one is read only by stage two
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  // a bit changes only once stages two and three agree
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end
    else
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= (s2_r & s3_r) | (q_r & (s2_r ^ s3_r));
    end
  end
  assign q_o = q_r;
endmodule
`default_nettype wire

// File: src/asrh_ctrl.sv
// host controller driving an 8k x 8 async sram with two selects
`timescale 1ns/1ps
`default_nettype none
module asrh_ctrl
  import asrh_pkg::*;
#(
  parameter bit OE_LOW_IN_WRITE = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire asrh_pkg::asrh_req_s req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [asrh_pkg::DATA_W-1:0] rsp_data_o,
  output asrh_pkg::asrh_pins_s pins_o,
  input wire logic [asrh_pkg::DATA_W-1:0] data_i,
  output logic [asrh_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o
);
  import asrh_pkg::*;

  // cycle states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RSETUP,
    ST_RWAIT,
    ST_WSETUP,
    ST_WPULSE,
    ST_WEND
  } asrh_state_e;

  // write pulse length depends on whether output enable stays low
  localparam logic [CNT_W-1:0] WP_LEN = OE_LOW_IN_WRITE ?
    CNT_W'((WP_OE_CYC > WP_CYC) ? WP_OE_CYC : WP_CYC) : CNT_W'(WP_CYC);
  localparam logic [CNT_W-1:0] RD_LEN = CNT_W'(RD_CYC);

  asrh_state_e state_r; // current state
  asrh_state_e state_nxt; // next state
  logic [CNT_W-1:0] cnt_r; // cycles left in a phase
  logic [CNT_W-1:0] cnt_nxt;
  asrh_pins_s pins_r; // registered pin levels
  asrh_pins_s pins_nxt;
  logic [DATA_W-1:0] wdata_r; // write data held on the bus
  logic [DATA_W-1:0] wdata_nxt;
  logic data_oe_r; // host bus drive
  logic data_oe_nxt;
  logic ready_r; // idle and able to accept
  logic rsp_valid_r; // one-cycle read answer
  logic rsp_valid_nxt;
  logic [DATA_W-1:0] rsp_data_r;
  logic [DATA_W-1:0] rsp_data_nxt;
  logic [DATA_W-1:0] rd_sync; // bus read after the pin synchroniser
  logic take; // request accepted this cycle
  logic cnt_done; // phase counter exhausted

  // bus from the device is outside the clock domain
  asrh_sync #(
    .W(DATA_W)
  ) u_rd_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .d_i(data_i),
    .q_o(rd_sync)
  );

  assign take = ready_r && req_valid_i;
  assign cnt_done = (cnt_r == '0);

  // sequencing: address and selects settle before the strobe moves
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_done ? cnt_r : cnt_r - 1'b1;
    pins_nxt = pins_r;
    wdata_nxt = wdata_r;
    data_oe_nxt = data_oe_r;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt = rsp_data_r;
    case (state_r)
      ST_IDLE:
      begin
        // deselected and quiet while idle
        pins_nxt.write_n = 1'b1;
        pins_nxt.select_active_low = 1'b1;
        pins_nxt.select_active_high = 1'b0;
        pins_nxt.output_enable_n = 1'b1;
        data_oe_nxt = 1'b0;
        if (take)
        begin
          // address only moves with strobe high
          pins_nxt.addr = req_i.addr;
          pins_nxt.select_active_low = 1'b0;
          pins_nxt.select_active_high = 1'b1;
          if (req_i.write)
          begin
            wdata_nxt = req_i.wdata;
            // output enable low only if the stretch option is set
            pins_nxt.output_enable_n = ~OE_LOW_IN_WRITE;
            state_nxt = ST_WSETUP;
          end
          else
          begin
            pins_nxt.output_enable_n = 1'b0;
            cnt_nxt = RD_LEN;
            state_nxt = ST_RSETUP;
          end
        end
      end
      ST_RSETUP:
      begin
        // strobe held high all the read; host never drives the bus
        pins_nxt.write_n = 1'b1;
        data_oe_nxt = 1'b0;
        if (cnt_done)
        begin
          // allow the three-stage synchroniser to catch up
          cnt_nxt = CNT_W'(3);
          state_nxt = ST_RWAIT;
        end
      end
      ST_RWAIT:
      begin
        if (cnt_done)
        begin
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt = rd_sync;
          pins_nxt.output_enable_n = 1'b1;
          pins_nxt.select_active_low = 1'b1;
          pins_nxt.select_active_high = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      ST_WSETUP:
      begin
        // selects already on: strobe falls after select, so a
        // strobe-controlled write; drive data from the strobe fall
        pins_nxt.write_n = 1'b0;
        data_oe_nxt = 1'b1;
        cnt_nxt = WP_LEN - 1'b1;
        state_nxt = ST_WPULSE;
      end
      ST_WPULSE:
      begin
        // pulse spans the float delay plus data setup when oe low
        if (cnt_done)
        begin
          pins_nxt.write_n = 1'b1;
          // outputs off with the strobe rise: our data still stands
          pins_nxt.output_enable_n = 1'b1;
          state_nxt = ST_WEND;
        end
      end
      ST_WEND:
      begin
        // data held one cycle past strobe rise, then release
        data_oe_nxt = 1'b0;
        pins_nxt.select_active_low = 1'b1;
        pins_nxt.select_active_high = 1'b0;
        pins_nxt.output_enable_n = 1'b1;
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state and counter
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // pin registers: strobe and output enable high, deselected
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pins_r <= '{addr: '0, select_active_low: 1'b1,
                  select_active_high: 1'b0, write_n: 1'b1,
                  output_enable_n: 1'b1};
      wdata_r <= '0;
      data_oe_r <= 1'b0;
    end
    else
    begin
      pins_r <= pins_nxt;
      wdata_r <= wdata_nxt;
      data_oe_r <= data_oe_nxt;
    end
  end

  // user handshake registers
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= '0;
    end
    else
    begin
      ready_r <= (state_nxt == ST_IDLE) && !take;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r <= rsp_data_nxt;
    end
  end

  assign req_ready_o = ready_r;
  assign rsp_valid_o = rsp_valid_r;
  assign rsp_data_o = rsp_data_r;
  assign pins_o = pins_r;
  assign data_o = wdata_r;
  assign data_oe_o = data_oe_r;
endmodule
`default_nettype wire

// File: sim/asrh_sram_model.sv
// behavioural 8k x 8 static ram with two selects, no clock
`timescale 1ns/1ps
`default_nettype none
module asrh_sram_model
  import asrh_pkg::*;
(
  input wire asrh_pkg::asrh_pins_s pins_i,
  input wire logic [asrh_pkg::DATA_W-1:0] bus_i,
  output logic [asrh_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o
);
  logic [DATA_W-1:0] mem [WORDS];
  // both selects needed, or the part ignores everything
  wire sel = !pins_i.select_active_low && pins_i.select_active_high;
  // level write: stores for as long as the overlap lasts
  always @*
    if (sel && !pins_i.write_n)
      mem[pins_i.addr] = bus_i;
  // strobe low keeps pins floating, so a late select cannot drive
  assign dq_oe_o = sel && pins_i.write_n && !pins_i.output_enable_n;
  assign dq_o = mem[pins_i.addr];
endmodule
`default_nettype wire

// File: sim/asrh_ctrl_assertions.sv
// pin-level checks on the host controller
`timescale 1ns/1ps
`default_nettype none
module asrh_ctrl_assertions
  import asrh_pkg::*;
#(
  parameter bit OE_LOW_IN_WRITE = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire asrh_pkg::asrh_req_s req_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire asrh_pkg::asrh_pins_s pins_o,
  input wire logic data_oe_o
);
  localparam int RD_LO = RD_CYC + 6; // answer may land on either edge
  localparam int RD_HI = RD_CYC + 7;
  // strobe-low cycles: stretched when output enable stays low
  localparam int WP_A = OE_LOW_IN_WRITE ?
    ((WP_OE_CYC > WP_CYC) ? WP_OE_CYC : WP_CYC) : WP_CYC;
  logic [3:0] low_cnt; // consecutive sampled cycles with strobe low
  // saturating count of strobe-low cycles, cleared while strobe high
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      low_cnt <= 4'h0;
    else if (pins_o.write_n)
      low_cnt <= 4'h0;
    else if (low_cnt != 4'hF)
      low_cnt <= low_cnt + 4'h1;
  end
  wire sel = !pins_o.select_active_low && pins_o.select_active_high;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_rd_take;
    req_valid_i && req_ready_o && !req_i.write;
  endsequence
  sequence s_strobe;
    $fell(pins_o.write_n);
  endsequence
  a_sel_pair: assert property (
    pins_o.select_active_low == !pins_o.select_active_high)
    else $error("selects out of step");
  a_addr_hold: assert property (
    !pins_o.write_n || !$past(pins_o.write_n) |-> $stable(pins_o.addr))
    else $error("address moved under strobe");
  a_strobe_sel: assert property (
    !pins_o.write_n |-> sel && data_oe_o
    && (OE_LOW_IN_WRITE || pins_o.output_enable_n))
    else $error("strobe without select or data");
  a_no_fight: assert property (
    data_oe_o |-> !(sel && pins_o.write_n && !pins_o.output_enable_n))
    else $error("bus contention");
  a_read_strobe: assert property (
    s_rd_take |=> pins_o.write_n [*6])
    else $error("strobe low in read");
  a_pulse_len: assert property (
    s_strobe |-> ##WP_A (pins_o.write_n && low_cnt == WP_A))
    else $error("write pulse length");
  a_read_ans: assert property (
    s_rd_take |-> ##[RD_LO:RD_HI] rsp_valid_o)
    else $error("read answer late");
endmodule
bind asrh_ctrl asrh_ctrl_assertions #(.OE_LOW_IN_WRITE(OE_LOW_IN_WRITE))
  asrh_ctrl_assertions_i (.clock_i(clock_i), .rst_i(rst_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
  .rsp_valid_o(rsp_valid_o), .pins_o(pins_o), .data_oe_o(data_oe_o));
`default_nettype wire

// File: sim/asrh_ctrl_tb_top.sv
// self-checking bench: controller against the ram model
`timescale 1ns/1ps
`default_nettype none
module asrh_ctrl_tb_top;
  import asrh_pkg::*;
  logic clock_i = 1'b0; // 10 mhz
  logic rst_i = 1'b1; // held 20 cycles
  logic req_valid_i = 1'b0;
  asrh_req_s req_i = '0;
  logic req_ready_o, rsp_valid_o, data_oe_o, m_oe;
  logic [DATA_W-1:0] rsp_data_o, data_o, data_i, m_dq;
  logic [DATA_W-1:0] bus_last = 8'h00;
  asrh_pins_s pins_o;
  // second controller, output enable held low through writes
  logic ready2, rsp_valid2, data_oe2, m_oe2;
  logic [DATA_W-1:0] rsp_data2, data_o2, data_i2, m_dq2;
  logic [DATA_W-1:0] bus_last2 = 8'h00;
  asrh_pins_s pins2;
  logic [DATA_W-1:0] shadow [WORDS]; // expected image
  logic [15:0] lfsr = 16'h097D; // seed 2429
  int errors = 0;
  int comparisons = 0;
  always #50 clock_i = ~clock_i;
  // a released bus toggles, so a stale value cannot pass
  always @(posedge clock_i) bus_last <= data_i;
  assign data_i = m_oe ? m_dq : (data_oe_o ? data_o : ~bus_last);
  always @(posedge clock_i) bus_last2 <= data_i2;
  assign data_i2 = m_oe2 ? m_dq2 : (data_oe2 ? data_o2 : ~bus_last2);
  asrh_ctrl asrh_ctrl_i (.clock_i(clock_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .pins_o(pins_o),
    .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o));
  asrh_sram_model asrh_sram_model_i (.pins_i(pins_o), .bus_i(data_i),
    .dq_o(m_dq), .dq_oe_o(m_oe));
  // same stimulus; read and write timing match the first instance
  asrh_ctrl #(
    .OE_LOW_IN_WRITE(1'b1)
  ) asrh_ctrl_oe_i (.clock_i(clock_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(ready2),
    .rsp_valid_o(rsp_valid2), .rsp_data_o(rsp_data2), .pins_o(pins2),
    .data_i(data_i2), .data_o(data_o2), .data_oe_o(data_oe2));
  asrh_sram_model asrh_sram_model_oe_i (.pins_i(pins2), .bus_i(data_i2),
    .dq_o(m_dq2), .dq_oe_o(m_oe2));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check_byte(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_pins(input asrh_pins_s got);
    comparisons++;
    if (got !== {13'h0000, 4'hB})
    begin
      errors++;
      $display("ERROR pins expected %h seen %h", {13'h0000, 4'hB}, got);
    end
  endtask
  // bounded wait on both readies (0) or both read answers (1)
  task automatic wait_hi(input bit sel_rsp);
    int n;
    n = 0;
    while ((sel_rsp ? (rsp_valid_o && rsp_valid2) :
      (req_ready_o && ready2)) !== 1'b1 && n < 40)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n >= 40)
    begin
      errors++;
      results();
    end
  endtask
  // one request, held until taken; reads compare with the image
  task automatic access(input logic wr, input logic [12:0] a,
    input logic [7:0] d);
    @(posedge clock_i);
    #1;
    wait_hi(1'b0);
    req_valid_i = 1'b1;
    req_i = {wr, a, d};
    @(posedge clock_i);
    #1;
    req_valid_i = 1'b0;
    if (wr)
      shadow[a] = d;
    else
    begin
      wait_hi(1'b1);
      check_byte("read data", shadow[a], rsp_data_o);
      check_byte("read data oe low", shadow[a], rsp_data2);
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clock_i);
    #1;
    check_pins(pins_o);
    check_pins(pins2);
    rst_i = 1'b0;
    // end words of the array first
    access(1'b1, 13'h0000, 8'hA5);
    access(1'b1, 13'h1FFF, 8'h5A);
    access(1'b0, 13'h0000, 8'h00);
    access(1'b0, 13'h1FFF, 8'h00);
    // random write then read-back, back to back
    repeat (30)
    begin
      lfsr = lfsr_next(lfsr);
      access(1'b1, lfsr[12:0], lfsr[15:8]);
      access(1'b0, lfsr[12:0], 8'h00);
    end
    // reset in mid-write must drop every pin to idle
    req_valid_i = 1'b1;
    req_i = {1'b1, 13'h0ABC, 8'h3C};
    // taken at the first edge, strobe low after the second
    repeat (2) @(posedge clock_i);
    #1;
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    #1;
    check_pins(pins_o);
    check_pins(pins2);
    check_byte("drive", 8'h00, {6'h00, data_oe_o, data_oe2});
    @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    access(1'b0, 13'h1FFF, 8'h00);
    results();
  end
endmodule
`default_nettype wire
